// ===== strb_pkg.sv
package strb_pkg;
    // Register byte addresses on the APB
    localparam logic [7:0] ADDR_FIFO_PORT = 8'h00;
    localparam logic [7:0] ADDR_COMMAND   = 8'h04;
    localparam logic [7:0] ADDR_MODE      = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_TIMER_HI  = 8'h10;
    localparam logic [7:0] ADDR_TIMER_LO  = 8'h14;
    localparam logic [7:0] ADDR_DEV_CTRL  = 8'h18;
    localparam logic [7:0] ADDR_AUX_CTRL  = 8'h1C;

    // Command register fields
    localparam int CMD_QUIESCE_SEL = 7;
    localparam int CMD_ERR_SEL     = 6;
    localparam int CMD_LINE_SEL    = 5;
    localparam int CMD_ADVANCE     = 4;
    localparam int CMD_ODD_PARITY  = 3;

    // Mode register fields
    localparam int MODE_SOFT_RESET = 7;
    localparam int MODE_LOOPBACK   = 6;
    localparam int MODE_REPEAT     = 5;
    localparam int MODE_RX_INVERT  = 4;
    localparam int MODE_TX_INVERT  = 3;
    localparam int MODE_PROTO_MSB  = 2;

    // Status register fields
    localparam int STAT_TX_FULL    = 7;
    localparam int STAT_TX_ACTIVE  = 6;
    localparam int STAT_RX_ERROR   = 5;
    localparam int STAT_RX_ACTIVE  = 4;
    localparam int STAT_DATA_AVAIL = 3;

    // Device control fields
    localparam int DCR_CPU_CLK_SEL = 7;
    localparam int DCR_INSTR_LSB   = 3;
    localparam int DCR_DATA_MSB    = 2;

    // Auxiliary control fields
    localparam int ACR_CLK_OUT_DIS = 2;

    // Error code bits
    localparam int ERR_OVERFLOW = 4;
    localparam int ERR_PARITY   = 3;
    localparam int ERR_ENDING   = 2;
    localparam int ERR_MIDBIT   = 1;
    localparam int ERR_RX_DIS   = 0;

    // Reset values
    localparam logic [7:0] RST_COMMAND  = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_DEV_CTRL = 8'h9F;
    localparam logic [7:0] RST_AUX_CTRL = 8'h00;
    localparam logic [7:0] RST_TIMER    = 8'h00;

    // FIFO depths
    localparam int          FIFO_DEPTH = 3;
    localparam logic [1:0]  FIFO_FULL  = 2'h3;

    // Protocol codes; bit 2 high with bit 1 low means twinax
    localparam logic [2:0] PROTO_TWINAX     = 3'h4;
    localparam logic [2:0] PROTO_TWINAX_ALL = 3'h5;
endpackage : strb_pkg

// ===== strb_regs.sv
// Local design decisions: the APB slave port and the register addresses.
module strb_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transmitter core side
    output logic      [11:0] tx_word,
    output logic             tx_word_valid,
    input  wire logic        tx_word_take,
    input  wire logic        tx_busy,
    input  wire logic        tx_busy_early,
    input  wire logic        tx_serial_raw,
    output logic             tx_serial_out,
    output logic             tx_active_output,
    // Receiver core side
    input  wire logic        data_in_pin,
    input  wire logic        analog_cmp,
    output logic             rx_serial,
    output logic             rx_enable,
    input  wire logic        rx_push,
    input  wire logic [10:0] rx_push_word,
    input  wire logic        rx_start,
    input  wire logic        rx_end,
    input  wire logic        line_active,
    input  wire logic        rx_err_parity,
    input  wire logic        rx_err_ending,
    input  wire logic        rx_err_midbit,
    // Transceiver control
    output logic             xcvr_reset,
    output logic      [2:0]  protocol_select,
    output logic             quiesce_count_select,
    output logic      [2:0]  data_wait_states,
    output logic      [1:0]  instr_wait_states,
    output logic             cpu_clk_half,
    output logic             clk_out_oe,
    output logic      [15:0] timer_value,
    output logic             tx_fifo_empty,
    output logic             rx_fifo_full
);
    // Software registers
    logic [7:0]  cmd_q;                  // Command register
    logic [7:0]  mode_q;                 // Mode register
    logic [7:0]  dcr_q;                  // Device control
    logic [7:0]  acr_q;                  // Auxiliary control
    logic [7:0]  thi_q;                  // Timer high byte
    logic [7:0]  tlo_q;                  // Timer low byte
    // FIFOs, head in slot 0 so outputs come from flops
    logic [11:0] txm_q [strb_pkg::FIFO_DEPTH];
    logic [10:0] rxm_q [strb_pkg::FIFO_DEPTH];
    logic [1:0]  txc_q;                  // Transmit word count
    logic [1:0]  rxc_q;                  // Receive word count
    // Status state
    logic [4:0]  err_q;                  // Error code bits
    logic        re_q;                   // Receiver error flag
    logic        ra_q;                   // Receiver active flag
    logic        dav_q;                  // Data available flag
    logic        la_q;                   // Line active, previous
    logic        ta_q;                   // Transmitter active status
    // APB response registers
    logic        rdy_q;
    logic [31:0] rdat_q;
    logic        serr_q;

    // Bus decode
    wire         acc     = psel & penable & rdy_q;
    wire         wr_acc  = acc & pwrite;
    wire         rd_acc  = acc & ~pwrite;
    wire         hit_prt = paddr == strb_pkg::ADDR_FIFO_PORT;
    wire         hit_cmd = paddr == strb_pkg::ADDR_COMMAND;
    wire         hit_mod = paddr == strb_pkg::ADDR_MODE;
    wire         hit_sta = paddr == strb_pkg::ADDR_STATUS;
    wire         hit_thi = paddr == strb_pkg::ADDR_TIMER_HI;
    wire         hit_tlo = paddr == strb_pkg::ADDR_TIMER_LO;
    wire         hit_dcr = paddr == strb_pkg::ADDR_DEV_CTRL;
    wire         hit_acr = paddr == strb_pkg::ADDR_AUX_CTRL;
    wire         mapped  = hit_prt | hit_cmd | hit_mod | hit_sta
                         | hit_thi | hit_tlo | hit_dcr | hit_acr;
    wire         ecr_sel = cmd_q[strb_pkg::CMD_ERR_SEL];

    // Port accesses split between FIFOs and error codes
    wire         ecr_rd  = rd_acc & hit_prt & ecr_sel;
    wire         fifo_rd = rd_acc & hit_prt & ~ecr_sel;
    wire         fifo_wr = wr_acc & hit_prt & ~ecr_sel;

    // Transceiver soft reset from mode bit
    wire         srst    = mode_q[strb_pkg::MODE_SOFT_RESET];
    wire         loop    = mode_q[strb_pkg::MODE_LOOPBACK];
    wire         twinax  = (mode_q[2:0] == strb_pkg::PROTO_TWINAX)
                         | (mode_q[2:0] == strb_pkg::PROTO_TWINAX_ALL);

    // FIFO occupancy
    wire         tx_full = txc_q == strb_pkg::FIFO_FULL;
    wire         rx_full = rxc_q == strb_pkg::FIFO_FULL;
    wire         tx_push = fifo_wr & ~tx_full;
    wire         tx_pop  = tx_word_take & (txc_q != 2'h0);
    wire         rx_pop  = fifo_rd & (rxc_q != 2'h0);
    wire         rx_in   = rx_push & (~rx_full | rx_pop);                 // Drain makes room
    wire         rx_ovf  = rx_push & rx_full & ~rx_pop;

    // Transmitter active, with or without half-bit advance
    wire         ta_d    = cmd_q[strb_pkg::CMD_ADVANCE] ? tx_busy_early
                                                        : tx_busy;

    // Receiver disabled while active by transmitter start
    wire         rdis_ev = ta_d & ~ta_q & ra_q
                         & ~mode_q[strb_pkg::MODE_REPEAT];

    // New error events, one bit each
    wire [4:0]   err_ev  = {rx_ovf, rx_err_parity, rx_err_ending,
                            rx_err_midbit, rdis_ev};
    wire         any_err = |err_ev;

    // Error read clears only the bits it reported; new events win
    wire [4:0]   err_clr = ecr_rd ? rdat_q[4:0] : 5'h00;
    wire [4:0]   err_d   = (err_q & ~err_clr) | err_ev;
    wire         re_d    = (re_q & ~ecr_rd) | any_err;

    // Receiver active: start sets, end or error clears
    wire         la_fall = la_q & ~line_active;
    wire         ra_clr  = rx_end | any_err | (twinax & la_fall);
    wire         ra_d    = rx_start | (ra_q & ~ra_clr);

    // Data available: an error clear sticks until a new word or a read
    wire [1:0]   rxc_n   = 2'(rxc_q + {1'b0, rx_in} - {1'b0, rx_pop});
    wire         dav_d   = ~any_err & (fifo_rd ? (rxc_n != 2'h0)
                                               : dav_q | rx_in);

    // Words entering the FIFOs
    wire [11:0]  tx_new  = {cmd_q[strb_pkg::CMD_ODD_PARITY],
                            cmd_q[2:0], pwdata[7:0]};
    wire [1:0]   txc_n   = 2'(txc_q + {1'b0, tx_push} - {1'b0, tx_pop});

    // Status byte shown to software
    wire [7:0]   status  = {tx_full, ta_q, re_q, ra_q, dav_q,
                            rxm_q[0][10:8]};

    // Read data mux
    wire [7:0]   rd_byte = hit_prt ? (ecr_sel ? {3'h0, err_q}
                                              : rxm_q[0][7:0])
                         : hit_cmd ? cmd_q
                         : hit_mod ? mode_q
                         : hit_sta ? status
                         : hit_thi ? thi_q
                         : hit_tlo ? tlo_q
                         : hit_dcr ? dcr_q
                         : hit_acr ? acr_q
                         : 8'h00;

    // Serial routing
    wire         rx_src  = loop ? tx_serial_raw
                         : cmd_q[strb_pkg::CMD_LINE_SEL] ? analog_cmp
                                                         : data_in_pin;

    // APB response: one wait state, data captured with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
            serr_q <= 1'b0;
        end else begin
            rdy_q  <= psel & penable & ~rdy_q;
            rdat_q <= {24'h00_0000, rd_byte};
            serr_q <= psel & penable & ~rdy_q & ~mapped;
        end
    end

    // Software-written registers; chip reset only, soft reset spares them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q  <= strb_pkg::RST_COMMAND;
            mode_q <= strb_pkg::RST_MODE;
            dcr_q  <= strb_pkg::RST_DEV_CTRL;
            acr_q  <= strb_pkg::RST_AUX_CTRL;
            thi_q  <= strb_pkg::RST_TIMER;
            tlo_q  <= strb_pkg::RST_TIMER;
        end else begin
            if (wr_acc && hit_cmd) cmd_q  <= pwdata[7:0];
            if (wr_acc && hit_mod) mode_q <= pwdata[7:0];
            if (wr_acc && hit_dcr) dcr_q  <= pwdata[7:0];
            if (wr_acc && hit_acr) acr_q  <= pwdata[7:0];
            if (wr_acc && hit_thi) thi_q  <= pwdata[7:0];
            if (wr_acc && hit_tlo) tlo_q  <= pwdata[7:0];
        end
    end

    // Transmit FIFO as a shift queue; a push to a full queue is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txc_q <= 2'h0;
            for (int i = 0; i < strb_pkg::FIFO_DEPTH; i++) txm_q[i] <= 12'h000;
        end else if (srst) begin
            txc_q <= 2'h0;
        end else begin
            txc_q <= txc_n;
            for (int i = 0; i < strb_pkg::FIFO_DEPTH; i++) begin
                if (tx_push && 2'(i) == txc_q - {1'b0, tx_pop}) begin
                    txm_q[i] <= tx_new;
                end else if (tx_pop && i < strb_pkg::FIFO_DEPTH - 1) begin
                    txm_q[i] <= txm_q[i + 1];
                end
            end
        end
    end

    // Receive FIFO; overflow word is lost and flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxc_q <= 2'h0;
            for (int i = 0; i < strb_pkg::FIFO_DEPTH; i++) rxm_q[i] <= 11'h000;
        end else if (srst) begin
            rxc_q <= 2'h0;
        end else begin
            rxc_q <= rxc_n;
            for (int i = 0; i < strb_pkg::FIFO_DEPTH; i++) begin
                if (rx_in && 2'(i) == rxc_q - {1'b0, rx_pop}) begin
                    rxm_q[i] <= rx_push_word;
                end else if (rx_pop && i < strb_pkg::FIFO_DEPTH - 1) begin
                    rxm_q[i] <= rxm_q[i + 1];
                end
            end
        end
    end

    // Status flags; soft reset clears them, while la_q keeps sampling line_active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 5'h00;
            re_q  <= 1'b0;
            ra_q  <= 1'b0;
            dav_q <= 1'b0;
            la_q  <= 1'b0;
            ta_q  <= 1'b0;
        end else if (srst) begin
            err_q <= 5'h00;
            re_q  <= 1'b0;
            ra_q  <= 1'b0;
            dav_q <= 1'b0;
            la_q  <= line_active;
            ta_q  <= 1'b0;
        end else begin
            err_q <= err_d;
            re_q  <= re_d;
            ra_q  <= ra_d;
            dav_q <= dav_d;
            la_q  <= line_active;
            ta_q  <= ta_d;
        end
    end

    // Registered outputs toward the line and the processor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_word              <= 12'h000;
            tx_word_valid        <= 1'b0;
            tx_serial_out        <= 1'b0;
            tx_active_output     <= 1'b0;
            rx_serial            <= 1'b0;
            rx_enable            <= 1'b1;
            xcvr_reset           <= 1'b1;
            protocol_select      <= 3'h0;
            quiesce_count_select <= 1'b0;
            data_wait_states     <= strb_pkg::RST_DEV_CTRL[strb_pkg::DCR_DATA_MSB:0];
            instr_wait_states    <= strb_pkg::RST_DEV_CTRL[strb_pkg::DCR_INSTR_LSB +: 2];
            cpu_clk_half         <= strb_pkg::RST_DEV_CTRL[strb_pkg::DCR_CPU_CLK_SEL];
            clk_out_oe           <= ~strb_pkg::RST_AUX_CTRL[strb_pkg::ACR_CLK_OUT_DIS];
            timer_value          <= 16'h0000;
            tx_fifo_empty        <= 1'b1;
            rx_fifo_full         <= 1'b0;
        end else begin
            // Head of queue after this cycle's shift
            tx_word              <= (tx_pop && txc_q > 2'h1) ? txm_q[1]
                                  : (txc_q == 2'h0 || (tx_pop && txc_q == 2'h1))
                                    ? tx_new : txm_q[0];
            tx_word_valid        <= ~srst & (txc_n != 2'h0);
            tx_serial_out        <= tx_serial_raw
                                  ^ mode_q[strb_pkg::MODE_TX_INVERT];
            tx_active_output     <= ta_d & ~loop;
            rx_serial            <= rx_src
                                  ^ mode_q[strb_pkg::MODE_RX_INVERT];
            rx_enable            <= mode_q[strb_pkg::MODE_REPEAT] | ~ta_d;
            xcvr_reset           <= srst;
            protocol_select      <= mode_q[strb_pkg::MODE_PROTO_MSB:0];
            quiesce_count_select <= cmd_q[strb_pkg::CMD_QUIESCE_SEL];
            data_wait_states     <= dcr_q[strb_pkg::DCR_DATA_MSB:0];
            instr_wait_states    <= dcr_q[strb_pkg::DCR_INSTR_LSB +: 2];
            cpu_clk_half         <= dcr_q[strb_pkg::DCR_CPU_CLK_SEL];
            clk_out_oe           <= ~acr_q[strb_pkg::ACR_CLK_OUT_DIS];
            timer_value          <= {thi_q, tlo_q};
            tx_fifo_empty        <= srst | (txc_n == 2'h0);
            rx_fifo_full         <= ~srst & (rxc_n == strb_pkg::FIFO_FULL);
        end
    end

    // Bus outputs straight from the response flops
    assign prdata  = rdat_q;
    assign pready  = rdy_q;
    assign pslverr = serr_q;
endmodule : strb_regs

// ===== strb_regs_chk.sv
module strb_regs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [11:0] tx_word,
    input wire logic        tx_word_valid,
    input wire logic        tx_fifo_empty,
    input wire logic        tx_busy,
    input wire logic        tx_busy_early,
    input wire logic        tx_serial_raw,
    input wire logic        tx_serial_out,
    input wire logic        tx_active_output,
    input wire logic        data_in_pin,
    input wire logic        analog_cmp,
    input wire logic        rx_serial,
    input wire logic        xcvr_reset,
    input wire logic [2:0]  protocol_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] cmd_q;  // Shadow of the command register
    logic [7:0] mode_q; // Shadow of the mode register
    logic       wr_c;   // A write commits at this edge
    assign wr_c = psel && penable && pready && pwrite;
    // Shadows follow committed writes only, so wait cycles leave them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q  <= 8'h00;
            mode_q <= 8'h00;
        end else if (wr_c && paddr == strb_pkg::ADDR_COMMAND) begin
            cmd_q <= pwdata[7:0];
        end else if (wr_c && paddr == strb_pkg::ADDR_MODE) begin
            mode_q <= pwdata[7:0];
        end
    end
    // Port write that reaches the transmit FIFO, not the error codes
    sequence port_wr;
        wr_c && paddr == strb_pkg::ADDR_FIFO_PORT && !cmd_q[6] && !mode_q[7];
    endsequence
    sequence loop_held;
        mode_q[6] ##1 mode_q[6];
    endsequence
    sequence apb_access;
        psel && !penable ##1 psel && penable;
    endsequence
    chk_tx_push: assert property (
        port_wr ##0 tx_fifo_empty |=> tx_word_valid && !tx_fifo_empty
            && tx_word == {$past(cmd_q[3:0]), $past(pwdata[7:0])})
        else $error("transmit word not pushed as written");
    chk_tx_active: assert property ($past(presetn) |-> tx_active_output ==
        $past(!mode_q[6] && (cmd_q[4] ? tx_busy_early : tx_busy)))
        else $error("transmitter active output wrong");
    chk_loop_quiet: assert property (loop_held |-> !tx_active_output)
        else $error("active output high in loopback");
    chk_tx_invert: assert property ($past(presetn) |->
        tx_serial_out == $past(tx_serial_raw ^ mode_q[3]))
        else $error("transmit serial data wrong");
    chk_rx_path: assert property ($past(presetn) |-> rx_serial ==
        $past((mode_q[6] ? tx_serial_raw : (cmd_q[5] ? analog_cmp : data_in_pin)) ^ mode_q[4]))
        else $error("receive serial source wrong");
    chk_soft_reset: assert property ($past(presetn) |-> xcvr_reset == $past(mode_q[7]))
        else $error("transceiver reset does not follow mode bit");
    chk_proto_sel: assert property (
        $changed(mode_q[2:0]) |=> protocol_select == $past(mode_q[2:0]))
        else $error("protocol select not applied");
    chk_ready_wait: assert property (apb_access |-> !pready ##1 pready)
        else $error("bus answer not after one wait cycle");
endmodule : strb_regs_chk

bind strb_regs strb_regs_chk u_chk (.*);

// ===== strb_core_model.sv
module strb_core_model (
    input  wire logic        pclk,
    input  wire logic [11:0] tx_word,
    input  wire logic        tx_word_valid,
    output logic             tx_word_take,
    output logic             tx_busy,
    output logic             tx_busy_early,
    output logic             tx_serial_raw,
    output logic             rx_push,
    output logic      [10:0] rx_push_word,
    output logic             rx_start,
    output logic             rx_end,
    output logic             line_active,
    output logic             rx_err_parity,
    output logic             rx_err_ending,
    output logic             rx_err_midbit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        go;     // Low stalls the consumer of transmit words
    logic [11:0] got[$]; // Transmit words in the order taken
    logic [4:0]  ev;     // One-cycle receive events
    assign {rx_start, rx_end, rx_err_parity, rx_err_ending, rx_err_midbit} = ev;
    initial begin
        {go, ev, tx_word_take, tx_busy, tx_busy_early, tx_serial_raw, rx_push} = '0;
        line_active  = 1'b0; // Line level is set by the bench
        rx_push_word = 11'h7FF;
    end
    // Slow consumer: takes at most every other cycle
    always @(posedge pclk) begin
        if (tx_word_take && tx_word_valid) got.push_back(tx_word);
        tx_word_take  <= go && tx_word_valid && !tx_word_take;
        tx_serial_raw <= !tx_serial_raw; // Changing pattern exposes stale paths
    end
    // One word per pulse; the word bus is scrambled when idle
    task automatic push(input logic [10:0] w);
        @(posedge pclk);
        rx_push      <= 1'b1;
        rx_push_word <= w;
        @(posedge pclk);
        rx_push      <= 1'b0;
        rx_push_word <= ~w;
    endtask : push
    // Raise a set of receive events for one cycle
    task automatic pulse(input logic [4:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 5'h00;
    endtask : pulse
endmodule : strb_core_model

// ===== tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_PORT = strb_pkg::ADDR_FIFO_PORT; // Short address aliases
    localparam logic [7:0] A_CMD  = strb_pkg::ADDR_COMMAND;
    localparam logic [7:0] A_MODE = strb_pkg::ADDR_MODE;
    localparam logic [7:0] A_STAT = strb_pkg::ADDR_STATUS;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] tx_word;
    logic [10:0] rx_push_word;
    logic [15:0] timer_value;
    logic [2:0]  protocol_select, data_wait_states;
    logic [1:0]  instr_wait_states;
    logic        tx_word_valid, tx_word_take, tx_busy, tx_busy_early, tx_serial_raw;
    logic        tx_serial_out, tx_active_output, data_in_pin, analog_cmp, rx_serial;
    logic        rx_enable, rx_push, rx_start, rx_end, line_active, rx_err_parity;
    logic        rx_err_ending, rx_err_midbit, xcvr_reset, quiesce_count_select;
    logic        cpu_clk_half, clk_out_oe, tx_fifo_empty, rx_fifo_full;
    int          fails, num_checks;
    logic [11:0] txw[3] = '{12'hDA5, 12'hD3C, 12'h277}; // Parity, upper bits, byte
    logic [10:0] rxw[3] = '{11'h5A1, 11'h2B2, 11'h7C3}; // Received words
    strb_regs       u_dut  (.*);
    strb_core_model u_core (.*);
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare
    // One transfer: setup, then access held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never gets an answer
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : xfer
    // Mask hides receive head bits while the receive FIFO is empty
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        xfer(1'b0, a, 32'h0000_0000);
        compare(rd & m, e);
    endtask : rchk
    task automatic tally_and_finish();
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, data_in_pin, analog_cmp, paddr, pwdata} = '0;
        {fails, num_checks} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, an unmapped address, then plain storage
        rchk(strb_pkg::ADDR_DEV_CTRL, 32'h0000_009F);
        rchk(strb_pkg::ADDR_AUX_CTRL, 32'h0000_0000);
        rchk(8'h20, 32'h0000_0000);
        compare({31'h0, err}, 32'h1);
        xfer(1'b1, strb_pkg::ADDR_DEV_CTRL, 32'h0000_0000);
        xfer(1'b1, strb_pkg::ADDR_AUX_CTRL, 32'h0000_0004);
        xfer(1'b1, strb_pkg::ADDR_TIMER_HI, 32'h0000_0012);
        xfer(1'b1, strb_pkg::ADDR_TIMER_LO, 32'h0000_0034);
        repeat (2) @(posedge pclk);
        compare({26'h0, cpu_clk_half, instr_wait_states, data_wait_states}, 0);
        compare({31'h0, clk_out_oe}, 32'h0);
        compare({16'h0, timer_value}, 32'h0000_1234);
        // Every protocol code
        for (int p = 0; p < 8; p++) begin
            xfer(1'b1, A_MODE, 32'(p));
            repeat (2) @(posedge pclk);
            compare({29'h0, protocol_select}, 32'(p));
        end
        // Comparator source, inverts, advance, repeat, loopback, quiesce select
        xfer(1'b1, A_CMD, 32'h0000_00B0);
        xfer(1'b1, A_MODE, 32'h0000_0018);
        u_core.tx_busy_early <= 1'b1;
        data_in_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        compare({31'h0, tx_active_output}, 32'h1);
        compare({31'h0, quiesce_count_select}, 32'h1);
        u_core.tx_busy <= 1'b1;
        analog_cmp <= 1'b1;
        repeat (3) @(posedge pclk);
        compare({31'h0, rx_enable}, 32'h0);
        xfer(1'b1, A_MODE, 32'h0000_0038);
        repeat (2) @(posedge pclk);
        compare({31'h0, rx_enable}, 32'h1);
        xfer(1'b1, A_MODE, 32'h0000_0058);
        repeat (2) @(posedge pclk);
        compare({31'h0, tx_active_output}, 32'h0);
        rchk(A_STAT, 32'h0000_0040, 32'hF8);
        {u_core.tx_busy, u_core.tx_busy_early} <= 2'b00;
        xfer(1'b1, A_MODE, 32'h0000_0000);
        // Stalled consumer: three words fill the transmit FIFO
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, A_CMD, {28'h0, txw[i][11:8]});
            xfer(1'b1, A_PORT, {24'h0, txw[i][7:0]});
        end
        rchk(A_STAT, 32'h0000_0080, 32'hF8);
        u_core.go <= 1'b1;
        repeat (20) @(posedge pclk);
        compare(32'(u_core.got.size()), 32'h3);
        for (int i = 0; i < 3; i++) compare({20'h0, u_core.got[i]}, {20'h0, txw[i]});
        compare({31'h0, tx_fifo_empty}, 32'h1);
        // Receive FIFO filled, then drained in order
        for (int i = 0; i < 3; i++) u_core.push(rxw[i]);
        repeat (2) @(posedge pclk);
        compare({31'h0, rx_fifo_full}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            rchk(A_STAT, {28'h1, 1'b1, rxw[i][10:8]} & 32'hF, 32'hF);
            rchk(A_PORT, {24'h0, rxw[i][7:0]});
        end
        rchk(A_STAT, 32'h0000_0000, 32'hF8);
        // Errors: flag and code bits, cleared by a code read, word kept
        u_core.push(11'h611);
        u_core.pulse(5'b00110);
        rchk(A_STAT, 32'h0000_0026);
        xfer(1'b1, A_CMD, 32'h0000_0040);
        rchk(A_PORT, 32'h0000_000C);
        rchk(A_PORT, 32'h0000_0000);
        rchk(A_STAT, 32'h0000_0006);
        // Soft reset clears flags and FIFOs but keeps its own bit
        u_core.pulse(5'b00001);
        xfer(1'b1, A_MODE, 32'h0000_0080);
        rchk(A_MODE, 32'h0000_0080);
        rchk(A_STAT, 32'h0000_0000, 32'hF8);
        xfer(1'b1, A_MODE, 32'h0000_0000);
        rchk(A_PORT, 32'h0000_0000);
        xfer(1'b1, A_CMD, 32'h0000_0000);
        // Receiver activity follows start and end of message
        u_core.pulse(5'b10000);
        rchk(A_STAT, 32'h0000_0010, 32'hF8);
        u_core.pulse(5'b01000);
        rchk(A_STAT, 32'h0000_0000, 32'hF8);
        // Twinax: the line going quiet also ends receiver activity
        xfer(1'b1, A_MODE, 32'h0000_0004);
        u_core.line_active <= 1'b1;
        u_core.pulse(5'b10000);
        rchk(A_STAT, 32'h0000_0010, 32'hF8);
        u_core.line_active <= 1'b0;
        rchk(A_STAT, 32'h0000_0000, 32'hF8);
        tally_and_finish();
    end
endmodule : tb_top
